/* File: logic/art_annunciator.sv */
// Functional notes
// - display blank on entering normal operation until an error or trip is pending
// - display blanks again once every error and trip is acknowledged
// - errors logged, several at once, acknowledged oldest first
// - pending error shown as error prefix plus event number
// - detail button held alternates module address and sensor index every 2 s
// - detail button released returns display to current code
// - short confirm press acknowledges the displayed alarm
// - trip shown as trip code, logged, pending until acknowledged
// - confirm held 2 s shows ack text; release acknowledges all alarms
// - acknowledge refused while alarm source still active; alarm stays pending
// - all three trip outputs driven together at once on a trip event; here a trip arriving with the log full is dropped and drives no output
// - arc to trip output response well under 2 ms
// - fault alarm output driven together with the trip outputs
// - supervision contact closed when healthy, open on any pending error
// - module bus carries 1 to 31 detection modules
// - supervision contact recloses once all errors acknowledged
// - trip and fault alarm outputs released once trip acknowledged
// - alarms restored after power return; restored trip reactivates trip outputs; here reset clears the log and nothing is restored
// - confirm held at power up enters configuration instead of normal mode
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "art_regs.svh"

module art_annunciator #(
  parameter int LOG_DEPTH = 8,
  parameter int HOLD_CYC = `ART_HOLD_S * `ART_CLK_HZ,
  parameter int DEB_CYC = `ART_DEB_MS * (`ART_CLK_HZ / 1000)
)(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // events from module bus logic
  input wire logic evt_valid,
  input wire logic [5:0] evt_num,
  input wire logic [4:0] evt_module,
  input wire logic [2:0] evt_sensor,
  input wire logic trip_src_active,
  input wire logic [63:0] err_src_active,
  // front panel buttons
  input wire logic confirm_button,
  input wire logic detail_button,
  // contacts
  output logic [2:0] trip_out,
  output logic fault_alarm_out,
  output logic supervision_open,
  // display and mode
  output art_pkg::art_disp_e disp_kind,
  output logic [7:0] disp_value,
  output logic config_mode
);

  localparam int LW = $clog2(LOG_DEPTH + 1);
  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam int SW = $clog2(2 * DEB_CYC + 1);

  // buttons
  logic conf_level;
  logic conf_fall;
  logic det_level;

  art_debounce #(.DEB_CYC(DEB_CYC)) u_conf_deb (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .pin(confirm_button),
    .level(conf_level),
    .rise(),
    .fall(conf_fall)
  );

  art_debounce #(.DEB_CYC(DEB_CYC)) u_det_deb (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .pin(detail_button),
    .level(det_level),
    .rise(),
    .fall()
  );

  // mode state
  art_pkg::art_mode_e mode_reg;
  logic [SW-1:0] start_cnt_reg;
  wire start_done = start_cnt_reg == SW'(2 * DEB_CYC);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= art_pkg::mode_start;
      start_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      unique case (mode_reg)
        art_pkg::mode_start:
        begin
          // wait for the debouncer to settle before sampling the strap
          start_cnt_reg <= start_cnt_reg + SW'(1);
          if (start_done)
            mode_reg <= conf_level ? art_pkg::mode_config : art_pkg::mode_normal;
        end
        art_pkg::mode_config: mode_reg <= art_pkg::mode_config;
        art_pkg::mode_normal: mode_reg <= art_pkg::mode_normal;
      endcase
    end
  end

  wire normal = mode_reg == art_pkg::mode_normal;

  // confirm hold timing
  logic [CW-1:0] hold_cnt_reg;
  logic armed_reg;
  wire hold_hit = conf_level && !armed_reg && (hold_cnt_reg == CW'(HOLD_CYC - 1));
  logic sw_ack_one;
  logic sw_ack_all;
  wire ack_one = normal && ((conf_fall && !armed_reg) || sw_ack_one);
  wire ack_all = normal && ((conf_fall && armed_reg) || sw_ack_all);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_cnt_reg <= '0;
      armed_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      hold_cnt_reg <= (conf_level && !armed_reg) ? hold_cnt_reg + CW'(1) : '0;
      if (hold_hit)
        armed_reg <= 1'b1;
      else if (!conf_level)
        armed_reg <= 1'b0;
    end
  end

  // event log, oldest at index 0
  logic [LW-1:0] count_reg;
  logic [LOG_DEPTH-1:0] ent_pend_reg;
  logic [LOG_DEPTH-1:0] ent_trip_reg;
  logic [5:0] ent_num_reg [LOG_DEPTH];
  logic [4:0] ent_mod_reg [LOG_DEPTH];
  logic [2:0] ent_sns_reg [LOG_DEPTH];
  wire [LOG_DEPTH-1:0] ent_pend_next;
  wire [LOG_DEPTH-1:0] ent_trip_next;
  wire [LOG_DEPTH-1:0] kept;
  wire [5:0] ent_num_next [LOG_DEPTH];
  wire [4:0] ent_mod_next [LOG_DEPTH];
  wire [2:0] ent_sns_next [LOG_DEPTH];
  logic [4:0] nmod_reg;
  logic drop_reg;

  // acknowledged head leaves the log one entry per cycle
  wire shift = (count_reg != '0) && !ent_pend_reg[0];
  wire [LW-1:0] wr_idx = count_reg - LW'(shift);
  wire evt_trip = evt_num == `ART_EVT_TRIP;
  wire mod_ok = (evt_module >= `ART_NMOD_MIN) && (evt_module <= nmod_reg);
  wire evt_ok = evt_valid && normal && mod_ok;
  wire push = evt_ok && (wr_idx < LW'(LOG_DEPTH));
  wire [LW-1:0] count_next = wr_idx + LW'(push);

  genvar g;
  for (g = 0; g < LOG_DEPTH; g = g + 1)
  begin : g_ent
    wire src_act = ent_trip_reg[g] ? trip_src_active : err_src_active[ent_num_reg[g]];
    wire clr = (ack_all || (ack_one && g == 0)) && !src_act;
    wire load = push && (wr_idx == LW'(g));
    wire up_pend;
    wire up_trip;
    wire [5:0] up_num;
    wire [4:0] up_mod;
    wire [2:0] up_sns;
    assign kept[g] = ent_pend_reg[g] && !clr;
    if (g < LOG_DEPTH - 1)
    begin : g_up
      assign up_pend = kept[g+1];
      assign up_trip = ent_trip_reg[g+1];
      assign up_num = ent_num_reg[g+1];
      assign up_mod = ent_mod_reg[g+1];
      assign up_sns = ent_sns_reg[g+1];
    end
    else
    begin : g_top
      assign up_pend = 1'b0;
      assign up_trip = 1'b0;
      assign up_num = 6'h00;
      assign up_mod = 5'h00;
      assign up_sns = 3'h0;
    end
    assign ent_pend_next[g] = load ? 1'b1 : (shift ? up_pend : kept[g]);
    assign ent_trip_next[g] = load ? evt_trip : (shift ? up_trip : ent_trip_reg[g]);
    assign ent_num_next[g] = load ? evt_num : (shift ? up_num : ent_num_reg[g]);
    assign ent_mod_next[g] = load ? evt_module : (shift ? up_mod : ent_mod_reg[g]);
    assign ent_sns_next[g] = load ? evt_sensor : (shift ? up_sns : ent_sns_reg[g]);
  end

  // a pending trip anywhere in the log drives the trip and fault alarm outputs
  wire trip_any = |(ent_pend_next & ent_trip_next);
  wire err_any = |(ent_pend_next & ~ent_trip_next);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg <= '0;
      ent_pend_reg <= '0;
      ent_trip_reg <= '0;
      ent_num_reg <= '{default: 6'h00};
      ent_mod_reg <= '{default: 5'h00};
      ent_sns_reg <= '{default: 3'h0};
      trip_out <= 3'h0;
      fault_alarm_out <= 1'b0;
      supervision_open <= 1'b0;
      config_mode <= 1'b0;
    end
    else if (clk_en)
    begin
      count_reg <= count_next;
      ent_pend_reg <= ent_pend_next;
      ent_trip_reg <= ent_trip_next;
      ent_num_reg <= ent_num_next;
      ent_mod_reg <= ent_mod_next;
      ent_sns_reg <= ent_sns_next;
      // one register stage: 100 ns against a 2 ms budget
      trip_out <= {3{trip_any}};
      fault_alarm_out <= trip_any;
      supervision_open <= err_any;
      config_mode <= mode_reg == art_pkg::mode_config;
    end
  end

  // display
  logic [CW-1:0] det_cnt_reg;
  logic det_sns_reg;
  wire head_ok = normal && (count_reg != '0) && ent_pend_reg[0];
  wire det_hit = det_cnt_reg == CW'(HOLD_CYC - 1);
  art_pkg::art_disp_e kind_next;
  logic [7:0] value_next;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      det_cnt_reg <= '0;
      det_sns_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      // released or nothing shown: restart on the module address
      det_cnt_reg <= (det_level && head_ok && !det_hit) ? det_cnt_reg + CW'(1) : '0;
      if (!det_level || !head_ok)
        det_sns_reg <= 1'b0;
      else if (det_hit)
        det_sns_reg <= !det_sns_reg;
    end
  end

  always_comb
  begin
    kind_next = art_pkg::disp_blank;
    value_next = 8'h00;
    if (armed_reg && normal)
      kind_next = art_pkg::disp_ack;
    else if (head_ok && det_level)
    begin
      kind_next = det_sns_reg ? art_pkg::disp_sns : art_pkg::disp_mod;
      value_next = det_sns_reg ? {5'h00, ent_sns_reg[0]} : {3'h0, ent_mod_reg[0]};
    end
    else if (head_ok)
    begin
      kind_next = ent_trip_reg[0] ? art_pkg::disp_trip : art_pkg::disp_err;
      value_next = {2'h0, ent_num_reg[0]};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      disp_kind <= art_pkg::disp_blank;
      disp_value <= 8'h00;
    end
    else if (clk_en)
    begin
      disp_kind <= kind_next;
      disp_value <= value_next;
    end
  end

  // register bus
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire do_wr = aw_got_reg && w_got_reg && !s_axi_bvalid;
  wire wr_ctrl = do_wr && (aw_addr_reg == `ART_OFS_CTRL) && w_strb_reg[0];
  wire wr_nmod = do_wr && (aw_addr_reg == `ART_OFS_NMOD) && w_strb_reg[0];
  wire wr_map = (aw_addr_reg == `ART_OFS_CTRL) || (aw_addr_reg == `ART_OFS_NMOD);
  wire [4:0] nmod_in = w_data_reg[4:0];
  assign sw_ack_one = wr_ctrl && w_data_reg[`ART_CTRL_ACK_BIT];
  assign sw_ack_all = wr_ctrl && w_data_reg[`ART_CTRL_ACKALL_BIT];
  wire clr_drop = wr_ctrl && w_data_reg[`ART_CTRL_CLRDROP_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ART_RESP_OKAY;
      nmod_reg <= `ART_NMOD_RESET;
      drop_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (aw_hs)
      begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs)
      begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wr_nmod)
        nmod_reg <= (nmod_in < `ART_NMOD_MIN) ? `ART_NMOD_MIN : nmod_in;
      // a lost event wins over a clear in the same cycle
      if (evt_ok && !push)
        drop_reg <= 1'b1;
      else if (clr_drop)
        drop_reg <= 1'b0;
    end
  end

  wire [31:0] st_word = ({31'h0, |(ent_pend_reg & ent_trip_reg)} << `ART_ST_TRIP_BIT)
    | ({31'h0, |(ent_pend_reg & ~ent_trip_reg)} << `ART_ST_ERR_BIT)
    | ({31'h0, config_mode} << `ART_ST_CFG_BIT)
    | ({31'h0, drop_reg} << `ART_ST_DROP_BIT)
    | (32'(count_reg) << `ART_ST_CNT_POS);
  wire [31:0] hd_word = {26'h0, ent_num_reg[0]}
    | ({27'h0, ent_mod_reg[0]} << `ART_HD_MOD_POS)
    | ({29'h0, ent_sns_reg[0]} << `ART_HD_SNS_POS)
    | ({31'h0, ent_trip_reg[0]} << `ART_HD_TRIP_BIT)
    | ({31'h0, head_ok} << `ART_HD_VALID_BIT);
  wire rd_st = s_axi_araddr == `ART_OFS_STATUS;
  wire rd_hd = s_axi_araddr == `ART_OFS_HEAD;
  wire rd_nm = s_axi_araddr == `ART_OFS_NMOD;
  wire rd_ct = s_axi_araddr == `ART_OFS_CTRL;
  wire [31:0] rd_word = rd_st ? st_word : (rd_hd ? hd_word : (rd_nm ? {27'h0, nmod_reg} : 32'h0));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ART_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_st || rd_hd || rd_nm || rd_ct) ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: logic/art_regs.svh */
`ifndef ART_REGS_SVH
`define ART_REGS_SVH

// timing
`define ART_CLK_HZ 10000000
`define ART_HOLD_S 2
`define ART_DEB_MS 10
`define ART_RESP_MS 2

// register offsets
`define ART_OFS_CTRL 8'h00
`define ART_OFS_STATUS 8'h04
`define ART_OFS_HEAD 8'h08
`define ART_OFS_NMOD 8'h0C

// control bits
`define ART_CTRL_ACK_BIT 0
`define ART_CTRL_ACKALL_BIT 1
`define ART_CTRL_CLRDROP_BIT 2

// status bits
`define ART_ST_TRIP_BIT 0
`define ART_ST_ERR_BIT 1
`define ART_ST_CFG_BIT 2
`define ART_ST_DROP_BIT 3
`define ART_ST_CNT_POS 8

// head entry fields
`define ART_HD_MOD_POS 8
`define ART_HD_SNS_POS 16
`define ART_HD_TRIP_BIT 24
`define ART_HD_VALID_BIT 31

// reset values and limits
`define ART_NMOD_RESET 5'h1F
`define ART_NMOD_MIN 5'h01
`define ART_EVT_TRIP 6'h0D
`define ART_RESP_OKAY 2'h0
`define ART_RESP_SLVERR 2'h2

`endif

/* File: logic/art_pkg.sv */
package art_pkg;

  typedef enum logic [2:0] {
    disp_blank = 3'b000,
    disp_err = 3'b001,
    disp_trip = 3'b010,
    disp_mod = 3'b011,
    disp_sns = 3'b100,
    disp_ack = 3'b101
  } art_disp_e;

  typedef enum logic [1:0] {
    mode_start = 2'b00,
    mode_config = 2'b01,
    mode_normal = 2'b10
  } art_mode_e;

endpackage

/* File: logic/art_debounce.sv */
`timescale 1ns/1ns
`default_nettype none

module art_debounce #(
  parameter int DEB_CYC = 100000
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // raw pin
  input wire logic pin,
  // clean level and edges
  output logic level,
  output logic rise,
  output logic fall
);

  localparam int DW = $clog2(DEB_CYC + 1);

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;
  logic rise_reg;
  logic fall_reg;
  logic [DW-1:0] cnt_reg;

  // a change counts only while the last two stages agree
  wire differs = (sync2_reg == sync3_reg) && (sync3_reg != level_reg);
  wire settled = differs && (cnt_reg == DW'(DEB_CYC - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      cnt_reg <= (differs && !settled) ? cnt_reg + DW'(1) : '0;
      if (settled)
        level_reg <= sync3_reg;
      rise_reg <= settled && sync3_reg;
      fall_reg <= settled && !sync3_reg;
    end
  end

  assign level = level_reg;
  assign rise = rise_reg;
  assign fall = fall_reg;

endmodule

`default_nettype wire

/* File: test/art_annunciator_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module art_annunciator_chk #(
  parameter int DEB_CYC = 100000
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // event side
  input wire logic evt_valid,
  input wire logic [5:0] evt_num,
  input wire logic [4:0] evt_module,
  input wire logic trip_src_active,
  input wire logic [63:0] err_src_active,
  // contacts and display
  input wire logic [2:0] trip_out,
  input wire logic fault_alarm_out,
  input wire logic supervision_open,
  input wire art_pkg::art_disp_e disp_kind,
  input wire logic [7:0] disp_value,
  input wire logic config_mode
);
  logic [7:0] up_reg;
  logic norm;
  logic idle;
  logic trip_evt;
  logic err_evt;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      up_reg <= 8'h00;
    else if (up_reg != 8'hFF)
      up_reg <= up_reg + 8'h01;
  end
  // margin past start-up sampling, so the mode has settled
  assign norm = (int'(up_reg) > 2 * DEB_CYC + 4) && !config_mode;
  assign idle = (trip_out == 3'h0) && !supervision_open;
  // a frozen block takes no event
  assign trip_evt = evt_valid && clk_en && norm && (evt_module != 5'h00) && (evt_num == 6'h0D);
  assign err_evt = evt_valid && clk_en && norm && (evt_module != 5'h00) && (evt_num != 6'h0D);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  trip_resp_a: assert property (trip_evt |=> trip_out == 3'h7 && fault_alarm_out)
    else $error("trip outputs late");
  err_resp_a: assert property (err_evt |=> supervision_open)
    else $error("supervision contact not opened");
  trip_equal_a: assert property (trip_out == 3'h0 || trip_out == 3'h7)
    else $error("trip outputs differ");
  fault_pair_a: assert property (fault_alarm_out == trip_out[2])
    else $error("fault alarm not with trip");
  trip_hold_a: assert property (trip_src_active && trip_out[0] |=> trip_out[0])
    else $error("trip released while source active");
  err_hold_a: assert property (supervision_open && err_src_active != 64'h0 |=> supervision_open)
    else $error("error released while source active");
  blank_idle_a: assert property (norm && idle && $past(idle) |->
    disp_kind == art_pkg::disp_blank || disp_kind == art_pkg::disp_ack)
    else $error("display not blank");
  trip_show_a: assert property ($rose(fault_alarm_out) && !supervision_open |=>
    disp_kind == art_pkg::disp_trip && disp_value == 8'h0D)
    else $error("trip code not shown");
  err_show_a: assert property ($rose(supervision_open) && !fault_alarm_out |=>
    disp_kind == art_pkg::disp_err && disp_value == {2'b00, $past(evt_num, 2)})
    else $error("error code not shown");
  cfg_hold_a: assert property (config_mode |=> config_mode && idle)
    else $error("config mode left or outputs set");
endmodule
`default_nettype wire

/* File: test/art_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
module art_far_model (
  // clock
  input wire logic aclk,
  // event lines
  output logic evt_valid,
  output logic [5:0] evt_num,
  output logic [4:0] evt_module,
  output logic [2:0] evt_sensor,
  output logic trip_src_active,
  output logic [63:0] err_src_active,
  // panel pins, low when released
  output logic confirm_button,
  output logic detail_button
);
  initial
  begin
    evt_valid = 1'b0;
    evt_num = 6'h00;
    evt_module = 5'h00;
    evt_sensor = 3'h0;
    trip_src_active = 1'b0;
    err_src_active = 64'h0;
    confirm_button = 1'b0;
    detail_button = 1'b0;
  end
  // one pulse per activation; the source stays active until quiet
  task send(input logic [5:0] n, input logic [4:0] m, input logic [2:0] s);
    @(posedge aclk);
    evt_valid <= 1'b1;
    evt_num <= n;
    evt_module <= m;
    evt_sensor <= s;
    if (n == 6'h0D)
      trip_src_active <= 1'b1;
    else
      err_src_active[n] <= 1'b1;
    @(posedge aclk);
    evt_valid <= 1'b0;
    // released lines must not keep the last value
    evt_num <= ~n;
    evt_module <= ~m;
    evt_sensor <= ~s;
  endtask
  task quiet(input logic [5:0] n);
    @(posedge aclk);
    if (n == 6'h0D)
      trip_src_active <= 1'b0;
    else
      err_src_active[n] <= 1'b0;
  endtask
  task btn(input logic c, input logic l);
    @(posedge aclk);
    if (c)
      confirm_button <= l;
    else
      detail_button <= l;
  endtask
  task press(input logic c, input int cyc);
    btn(c, 1'b1);
    repeat (cyc) @(posedge aclk);
    btn(c, 1'b0);
  endtask
endmodule
`default_nettype wire

/* File: test/art_annunciator_test.sv */
`timescale 1ns/1ns
`default_nettype none
module art_annunciator_test;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, disp_value;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid, s_axi_bvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic evt_valid, trip_src_active, confirm_button, detail_button;
  logic fault_alarm_out, supervision_open, config_mode, ta, tw, tb;
  logic [5:0] evt_num;
  logic [4:0] evt_module;
  logic [2:0] evt_sensor, trip_out;
  logic [63:0] err_src_active;
  art_pkg::art_disp_e disp_kind;
  int n_mismatch = 0, checked = 0, n;
  art_annunciator #(.HOLD_CYC(50), .DEB_CYC(4)) dut (.aclk, .aresetn, .clk_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .evt_valid, .evt_num, .evt_module, .evt_sensor,
    .trip_src_active, .err_src_active, .confirm_button, .detail_button, .trip_out,
    .fault_alarm_out, .supervision_open, .disp_kind, .disp_value, .config_mode);
  art_far_model far (.aclk, .evt_valid, .evt_num, .evt_module, .evt_sensor,
    .trip_src_active, .err_src_active, .confirm_button, .detail_button);
  always #50 aclk = ~aclk;
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task hang(input logic ok);
    if (!ok)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      print_verdict();
    end
  endtask
  // sample before the edge, release right after it
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 40)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      n++;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    hang(tb);
    check(32'(r), 32'(er));
  endtask
  task rd(input logic [7:0] a, input logic [1:0] er);
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tb && n < 40)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      r = s_axi_rresp;
      d = s_axi_rdata;
      n++;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    hang(tb);
    check(32'(r), 32'(er));
  endtask
  task wait_kind(input art_pkg::art_disp_e k, input int lim);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end while (disp_kind !== k && n < lim);
    hang(disp_kind === k);
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(negedge aclk);
    check(32'({disp_kind, disp_value, trip_out, supervision_open, config_mode}), 0);
    rd(8'h0C, 2'h0);
    check(d, 32'h1F);
    rd(8'h10, 2'h2);
    check(d, 32'h0);
    far.send(6'h0D, 5'd0, 3'd0);
    repeat (2) @(negedge aclk);
    check(32'(trip_out), 32'h0);
    far.quiet(6'h0D);
    $display("test startup done");
    far.send(6'h0D, 5'd3, 3'd2);
    @(negedge aclk);
    check(32'({trip_out, fault_alarm_out, supervision_open}), 32'h1E);
    @(negedge aclk);
    check(32'({disp_kind, disp_value}), 32'h20D);
    rd(8'h08, 2'h0);
    check(d, 32'h8102030D);
    far.btn(1'b0, 1'b1);
    wait_kind(art_pkg::disp_mod, 30);
    check(32'(disp_value), 32'h3);
    wait_kind(art_pkg::disp_sns, 60);
    check(32'({disp_value, 1'(n >= 49 && n <= 51)}), 32'h5);
    far.btn(1'b0, 1'b0);
    wait_kind(art_pkg::disp_trip, 30);
    check(32'(disp_value), 32'h0D);
    far.press(1'b1, 20);
    repeat (30) @(negedge aclk);
    check(32'(trip_out), 32'h7);
    far.quiet(6'h0D);
    far.press(1'b1, 20);
    wait_kind(art_pkg::disp_blank, 40);
    check(32'({trip_out, fault_alarm_out}), 32'h0);
    $display("test trip done");
    far.send(6'd20, 5'd1, 3'd0);
    far.send(6'd15, 5'd2, 3'd5);
    wait_kind(art_pkg::disp_err, 5);
    check(32'({disp_value, trip_out, supervision_open}), 32'h141);
    far.quiet(6'd20);
    far.quiet(6'd15);
    far.press(1'b1, 20);
    repeat (30) @(negedge aclk);
    check(32'({disp_value, supervision_open}), 32'h1F);
    far.press(1'b1, 20);
    wait_kind(art_pkg::disp_blank, 40);
    check(32'(supervision_open), 32'h0);
    $display("test errors done");
    far.send(6'h0D, 5'd4, 3'd1);
    far.send(6'd18, 5'd5, 3'd3);
    far.quiet(6'd18);
    far.btn(1'b1, 1'b1);
    wait_kind(art_pkg::disp_ack, 80);
    check(32'(n >= 50 && n <= 62), 32'h1);
    far.btn(1'b1, 1'b0);
    wait_kind(art_pkg::disp_trip, 40);
    repeat (5) @(negedge aclk);
    check(32'({trip_out, supervision_open}), 32'hE);
    far.quiet(6'h0D);
    wr(8'h00, 32'h1, 2'h0);
    wait_kind(art_pkg::disp_blank, 20);
    rd(8'h04, 2'h0);
    check(d, 32'h0);
    $display("test ack all done");
    wr(8'h0C, 32'h0, 2'h0);
    rd(8'h0C, 2'h0);
    check(d, 32'h1);
    wr(8'h0C, 32'h1F, 2'h0);
    wr(8'h40, 32'h1, 2'h2);
    s_axi_wstrb <= 4'hE;
    wr(8'h0C, 32'h3, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h0C, 2'h0);
    check(d, 32'h1F);
    $display("test registers done");
    clk_en <= 1'b0;
    far.send(6'h0D, 5'd1, 3'd0);
    repeat (3) @(posedge aclk);
    clk_en <= 1'b1;
    repeat (3) @(negedge aclk);
    check(32'(trip_out), 32'h0);
    far.quiet(6'h0D);
    $display("test freeze done");
    far.btn(1'b1, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(negedge aclk);
    far.send(6'h0D, 5'd1, 3'd0);
    repeat (2) @(negedge aclk);
    check(32'({config_mode, trip_out}), 32'h8);
    $display("test config done");
    print_verdict();
  end
endmodule
bind art_annunciator art_annunciator_chk #(.DEB_CYC(DEB_CYC)) chk (.aclk, .aresetn, .clk_en,
  .evt_valid, .evt_num, .evt_module, .trip_src_active, .err_src_active, .trip_out,
  .fault_alarm_out, .supervision_open, .disp_kind, .disp_value, .config_mode);
`default_nettype wire
